// ---- common/tc8_pkg.sv ----
// Package with register map, field layout, mode codes and reset values
package tc8_pkg;
  localparam int          TC8_W          = 8;
  localparam logic [4:0]  TC8_ADDR_CTRL  = 5'h00;
  localparam logic [4:0]  TC8_ADDR_COUNT = 5'h04;
  localparam logic [4:0]  TC8_ADDR_CMP   = 5'h08;
  localparam logic [4:0]  TC8_ADDR_FLAG  = 5'h0c;
  localparam logic [4:0]  TC8_ADDR_MASK  = 5'h10;
  localparam logic [4:0]  TC8_ADDR_STAT  = 5'h14;
  // Control word fields
  localparam int          TC8_CS_LSB     = 0;
  localparam int          TC8_WGM_LSB    = 3;
  localparam int          TC8_COM_LSB    = 5;
  localparam int          TC8_FORCE_BIT  = 7;
  // Flag and mask bit positions
  localparam int          TC8_OVF_BIT    = 0;
  localparam int          TC8_CMP_BIT    = 1;
  // Waveform modes
  localparam logic [1:0]  TC8_WGM_NORMAL = 2'h0;
  localparam logic [1:0]  TC8_WGM_PHASE  = 2'h1;
  localparam logic [1:0]  TC8_WGM_CTC    = 2'h2;
  localparam logic [1:0]  TC8_WGM_FAST   = 2'h3;
  // Clock select codes
  localparam logic [2:0]  TC8_CS_STOP    = 3'h0;
  localparam logic [2:0]  TC8_CS_DIV1    = 3'h1;
  localparam logic [2:0]  TC8_CS_DIV8    = 3'h2;
  localparam logic [2:0]  TC8_CS_DIV64   = 3'h3;
  localparam logic [2:0]  TC8_CS_DIV256  = 3'h4;
  localparam logic [2:0]  TC8_CS_DIV1024 = 3'h5;
  localparam logic [2:0]  TC8_CS_EXTFALL = 3'h6;
  localparam logic [2:0]  TC8_CS_EXTRISE = 3'h7;
  // Prescaler tap widths (divide by two to the power of the width)
  localparam int          TC8_PSC_W      = 10;
  localparam int          TC8_TAP8       = 3;
  localparam int          TC8_TAP64      = 6;
  localparam int          TC8_TAP256     = 8;
  localparam int          TC8_TAP1024    = 10;
  // Compare output actions
  localparam logic [1:0]  TC8_COM_OFF    = 2'h0;
  localparam logic [1:0]  TC8_COM_TOGGLE = 2'h1;
  localparam logic [1:0]  TC8_COM_CLEAR  = 2'h2;
  localparam logic [1:0]  TC8_COM_SET    = 2'h3;
  // Limits and reset values
  localparam logic [7:0]  TC8_BOTTOM     = 8'h00;
  localparam logic [7:0]  TC8_MAX        = 8'hff;
  localparam logic [7:0]  TC8_RST_BYTE   = 8'h00;
  localparam logic [1:0]  TC8_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  TC8_RESP_SLV   = 2'h2;

  typedef struct packed {
    logic [1:0] com;
    logic [1:0] wgm;
    logic [2:0] cs;
  } tc8_ctrl_s;
endpackage

// ---- rtl/tc8_timer.sv ----
// Eight-bit timer/counter with one compare channel behind AXI4-Lite
// Function
// - Counter and compare value are each eight bits wide.
// - Requests appear as flags in flag register, masked per bit by mask register.
// - Clock select picks prescaled clock or external pin edge as timer clock.
// - Clock select zero stops counter: no count, clear or flag activity.
// - Software may read and write the counter at any time.
// - A software counter write beats any same-cycle count or clear.
// - Bottom indication at 0x00, maximum indication at 0xff.
// - Top is 0xff or the compare value, depending on mode.
// - Each timer clock clears, increments or decrements per waveform mode.
// - Counting steps by exactly one; clear forces all bits zero.
// - Overflow flag set per mode and can raise an interrupt.
// - Equality sets the compare flag at the next timer clock.
// - Compare interrupt needs its enable bit and global enable.
// - Compare flag clears on interrupt execution or a written one.
// - Compare value double-buffered in PWM modes only.
// - Buffered value moves to active register only at top or bottom.
// - Software compare access hits buffer when buffered, else active register.
// - Force strobe in non-PWM modes acts on output state like a match.
// - Forced compare sets no flag and never clears or reloads counter.
// - Counter write blocks compare match in the next timer clock.
// - Output state kept across mode changes; output mode takes effect at once.
// - Mode zero counts up wrapping 0xff to 0x00; mode two clears on match.
// - Clear-on-match mode zeroes the counter at equality with compare value.
// - Normal mode sets overflow in the timer clock the counter becomes zero.
// - Output mode zero takes no action on output state at a match.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tc8_timer (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [4:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [4:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        EXTERNAL_COUNT_PIN,
  input  wire logic        GLOBAL_INT_EN,
  input  wire logic        OVF_INT_ACK,
  input  wire logic        CMP_INT_ACK,
  output logic             OVF_IRQ,
  output logic             CMP_IRQ,
  output logic             COMPARE_OUTPUT_STATE
);
  tc8_pkg::tc8_ctrl_s ctrl_r;
  logic [7:0]         cnt_r;
  logic [7:0]         cnt_nxt;
  logic [7:0]         ocr_r;
  logic [7:0]         ocr_nxt;
  logic [7:0]         buf_r;
  logic               dir_down_r;
  logic               dir_down_nxt;
  logic               oc_r;
  logic               oc_nxt;
  logic               block_r;
  logic               ovf_flag_r;
  logic               cmp_flag_r;
  logic               ovf_ie_r;
  logic               cmp_ie_r;
  logic               ovf_set;
  logic               cmp_set;
  logic [9:0]         psc_r;
  logic               ext_prev_r;
  logic               tick;
  logic               match;
  logic               pwm;
  logic               at_bottom;
  logic               at_max;
  logic [4:0]         awaddr_r;
  logic [7:0]         wdata_r;
  logic               wstrb0_r;
  logic               do_write;
  logic               wr_byte;
  logic               wr_count;
  logic               wr_cmp;
  logic               wr_ctrl;
  logic               wr_flag;
  logic               force_cmp;
  logic               addr_ok_w;
  logic [7:0]         rd_byte;
  logic               rd_ok;

  // Action a match applies to the output state
  function automatic logic com_act(input logic [1:0] com,
                                   input logic       cur,
                                   input logic       inv);
    logic r;
    r = cur;
    case (com)
      tc8_pkg::TC8_COM_TOGGLE: r = ~cur;
      tc8_pkg::TC8_COM_CLEAR:  r = inv;
      tc8_pkg::TC8_COM_SET:    r = ~inv;
      default:                 r = cur;
    endcase
    return r;
  endfunction

  // Write channel: address and data taken in either order
  assign do_write  = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign wr_byte   = do_write && wstrb0_r;
  assign wr_ctrl   = wr_byte && awaddr_r == tc8_pkg::TC8_ADDR_CTRL;
  assign wr_count  = wr_byte && awaddr_r == tc8_pkg::TC8_ADDR_COUNT;
  assign wr_cmp    = wr_byte && awaddr_r == tc8_pkg::TC8_ADDR_CMP;
  assign wr_flag   = wr_byte && awaddr_r == tc8_pkg::TC8_ADDR_FLAG;
  assign force_cmp = wr_ctrl && wdata_r[tc8_pkg::TC8_FORCE_BIT];
  assign addr_ok_w = awaddr_r <= tc8_pkg::TC8_ADDR_MASK;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= tc8_pkg::TC8_RESP_OKAY;
      awaddr_r      <= 5'h00;
      wdata_r       <= tc8_pkg::TC8_RST_BYTE;
      wstrb0_r      <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        S_AXI_AWREADY <= 1'b0;
        awaddr_r      <= {S_AXI_AWADDR[4:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        S_AXI_WREADY <= 1'b0;
        wdata_r      <= S_AXI_WDATA[7:0];
        wstrb0_r     <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= addr_ok_w ? tc8_pkg::TC8_RESP_OKAY
                                  : tc8_pkg::TC8_RESP_SLV;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Read channel, one cycle from address to data
  always_comb begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case ({S_AXI_ARADDR[4:2], 2'h0})
      tc8_pkg::TC8_ADDR_CTRL:  rd_byte = {1'b0, ctrl_r};
      tc8_pkg::TC8_ADDR_COUNT: rd_byte = cnt_r;
      tc8_pkg::TC8_ADDR_CMP:   rd_byte = pwm ? buf_r : ocr_r;
      tc8_pkg::TC8_ADDR_FLAG:  rd_byte = {6'h00, cmp_flag_r, ovf_flag_r};
      tc8_pkg::TC8_ADDR_MASK:  rd_byte = {6'h00, cmp_ie_r, ovf_ie_r};
      tc8_pkg::TC8_ADDR_STAT:  rd_byte = {5'h00, dir_down_r, at_max,
                                          at_bottom};
      default:                 rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= tc8_pkg::TC8_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h000000, rd_byte};
      S_AXI_RRESP   <= rd_ok ? tc8_pkg::TC8_RESP_OKAY : tc8_pkg::TC8_RESP_SLV;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Timer clock generation
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      psc_r      <= 10'h000;
      ext_prev_r <= 1'b0;
    end else begin
      psc_r      <= (ctrl_r.cs == tc8_pkg::TC8_CS_STOP) ? 10'h000
                                                        : psc_r + 10'h001;
      ext_prev_r <= EXTERNAL_COUNT_PIN;
    end
  end

  always_comb begin
    case (ctrl_r.cs)
      tc8_pkg::TC8_CS_DIV1:    tick = 1'b1;
      tc8_pkg::TC8_CS_DIV8:    tick = &psc_r[tc8_pkg::TC8_TAP8-1:0];
      tc8_pkg::TC8_CS_DIV64:   tick = &psc_r[tc8_pkg::TC8_TAP64-1:0];
      tc8_pkg::TC8_CS_DIV256:  tick = &psc_r[tc8_pkg::TC8_TAP256-1:0];
      tc8_pkg::TC8_CS_DIV1024: tick = &psc_r[tc8_pkg::TC8_TAP1024-1:0];
      tc8_pkg::TC8_CS_EXTFALL: tick = ext_prev_r & ~EXTERNAL_COUNT_PIN;
      tc8_pkg::TC8_CS_EXTRISE: tick = ~ext_prev_r & EXTERNAL_COUNT_PIN;
      default:                 tick = 1'b0;
    endcase
  end

  assign pwm       = ctrl_r.wgm == tc8_pkg::TC8_WGM_FAST ||
                     ctrl_r.wgm == tc8_pkg::TC8_WGM_PHASE;
  assign match     = (cnt_r == ocr_r) && !block_r;
  assign at_bottom = cnt_r == tc8_pkg::TC8_BOTTOM;
  assign at_max    = cnt_r == tc8_pkg::TC8_MAX;

  // Counter sequence, compare and output state
  always_comb begin
    cnt_nxt      = cnt_r;
    dir_down_nxt = dir_down_r;
    ocr_nxt      = ocr_r;
    oc_nxt       = oc_r;
    ovf_set      = 1'b0;
    cmp_set      = 1'b0;
    if (tick) begin
      case (ctrl_r.wgm)
        tc8_pkg::TC8_WGM_NORMAL: begin
          cnt_nxt = 8'(cnt_r + 8'h01);
          ovf_set = at_max;
        end
        tc8_pkg::TC8_WGM_CTC: begin
          cnt_nxt = match ? tc8_pkg::TC8_BOTTOM : 8'(cnt_r + 8'h01);
          ovf_set = at_max && !match;
        end
        tc8_pkg::TC8_WGM_FAST: begin
          cnt_nxt = 8'(cnt_r + 8'h01);
          ovf_set = at_max;
          if (at_max) begin
            ocr_nxt = buf_r;
          end
        end
        tc8_pkg::TC8_WGM_PHASE: begin
          if (!dir_down_r) begin
            cnt_nxt      = at_max ? 8'(cnt_r - 8'h01) : 8'(cnt_r + 8'h01);
            dir_down_nxt = at_max;
            if (at_max) begin
              ocr_nxt = buf_r;
            end
          end else begin
            cnt_nxt      = at_bottom ? 8'(cnt_r + 8'h01) : 8'(cnt_r - 8'h01);
            dir_down_nxt = !at_bottom;
            ovf_set      = at_bottom;
          end
        end
        default: cnt_nxt = cnt_r;
      endcase
      if (match) begin
        cmp_set = 1'b1;
        oc_nxt  = com_act(ctrl_r.com, oc_r,
                          ctrl_r.wgm == tc8_pkg::TC8_WGM_PHASE &&
                          dir_down_r);
      end
      if (ctrl_r.wgm == tc8_pkg::TC8_WGM_FAST && at_max &&
          ctrl_r.com[1]) begin
        oc_nxt = ~ctrl_r.com[0];
      end
    end
    if (force_cmp && !pwm) begin
      oc_nxt = com_act(ctrl_r.com, oc_nxt, 1'b0);
    end
    if (wr_count) begin
      cnt_nxt = wdata_r;
    end
    if (wr_cmp && !pwm) begin
      ocr_nxt = wdata_r;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt_r      <= tc8_pkg::TC8_RST_BYTE;
      ocr_r      <= tc8_pkg::TC8_RST_BYTE;
      buf_r      <= tc8_pkg::TC8_RST_BYTE;
      dir_down_r <= 1'b0;
      oc_r       <= 1'b0;
      block_r    <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      ocr_r      <= ocr_nxt;
      dir_down_r <= dir_down_nxt;
      oc_r       <= oc_nxt;
      if (wr_cmp) begin
        buf_r <= wdata_r;
      end
      if (wr_count) begin
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_r   <= '0;
      ovf_ie_r <= 1'b0;
      cmp_ie_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[6:0];
      end
      if (wr_byte && awaddr_r == tc8_pkg::TC8_ADDR_MASK) begin
        ovf_ie_r <= wdata_r[tc8_pkg::TC8_OVF_BIT];
        cmp_ie_r <= wdata_r[tc8_pkg::TC8_CMP_BIT];
      end
    end
  end

  // Hardware set wins over software or acknowledge clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ovf_flag_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_flag_r <= 1'b1;
      end else if (OVF_INT_ACK ||
                   (wr_flag && wdata_r[tc8_pkg::TC8_OVF_BIT])) begin
        ovf_flag_r <= 1'b0;
      end
      if (cmp_set) begin
        cmp_flag_r <= 1'b1;
      end else if (CMP_INT_ACK ||
                   (wr_flag && wdata_r[tc8_pkg::TC8_CMP_BIT])) begin
        cmp_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      OVF_IRQ              <= 1'b0;
      CMP_IRQ              <= 1'b0;
      COMPARE_OUTPUT_STATE <= 1'b0;
    end else begin
      OVF_IRQ              <= ovf_flag_r && ovf_ie_r && GLOBAL_INT_EN;
      CMP_IRQ              <= cmp_flag_r && cmp_ie_r && GLOBAL_INT_EN;
      COMPARE_OUTPUT_STATE <= oc_r;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_cnt_write_prio: assert property (wr_count |=> cnt_r == $past(wdata_r))
    else $error("counter write lost");
  a_stop_hold: assert property (
    ctrl_r.cs == tc8_pkg::TC8_CS_STOP && !wr_count
      |=> $stable(cnt_r) && !$rose(cmp_flag_r) && !$rose(ovf_flag_r))
    else $error("stopped timer changed");
  a_step_one: assert property (
    tick && ctrl_r.wgm == tc8_pkg::TC8_WGM_NORMAL && !wr_count
      |=> cnt_r == 8'($past(cnt_r) + 8'h01))
    else $error("normal step not one");
  a_ctc_clear: assert property (
    tick && ctrl_r.wgm == tc8_pkg::TC8_WGM_CTC && match && !wr_count
      |=> cnt_r == tc8_pkg::TC8_BOTTOM)
    else $error("clear on match missing");
  a_ovf_normal: assert property (
    tick && ctrl_r.wgm == tc8_pkg::TC8_WGM_NORMAL && at_max && !wr_count
      |=> ovf_flag_r && cnt_r == tc8_pkg::TC8_BOTTOM)
    else $error("overflow not set at wrap");
  a_cmp_flag_set: assert property (tick && match |=> cmp_flag_r)
    else $error("compare flag not set");
  a_match_block: assert property (
    wr_count ##1 (tick && !wr_count && !cmp_flag_r && !force_cmp)
      |=> !cmp_flag_r)
    else $error("match not blocked after counter write");
  a_cmp_irq_gate: assert property (
    ##1 CMP_IRQ == $past(cmp_flag_r && cmp_ie_r && GLOBAL_INT_EN))
    else $error("compare request gating wrong");
  a_buf_route: assert property (
    wr_cmp && pwm && !tick |=> $stable(ocr_r) && buf_r == $past(wdata_r))
    else $error("buffered write reached active register");
  a_com_off_hold: assert property (
    ctrl_r.com == tc8_pkg::TC8_COM_OFF |=> $stable(oc_r))
    else $error("output state moved with output mode off");
  a_force_noflag: assert property (
    force_cmp && !(tick && match) && !wr_count
      |=> $stable(cmp_flag_r) || !cmp_flag_r)
    else $error("forced compare set flag");

  c_ctc_wrap: cover property (
    tick && ctrl_r.wgm == tc8_pkg::TC8_WGM_CTC && match);
  c_phase_turn: cover property (
    tick && ctrl_r.wgm == tc8_pkg::TC8_WGM_PHASE && at_max ##1 dir_down_r);
  c_force: cover property (force_cmp && !pwm ##1 $changed(oc_r));
  c_blocked: cover property (wr_count ##1 tick && cnt_r == ocr_r);
endmodule

// ---- tb/tc8_host.sv ----
// Host model: AXI4-Lite master tasks and interrupt acknowledge
`timescale 1ns/1ps
module tc8_host (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic [4:0]       awa,
  output logic             awv,
  input  wire logic        awr,
  output logic [31:0]      wd,
  output logic [3:0]       ws,
  output logic             wv,
  input  wire logic        wrd,
  input  wire logic [1:0]  br,
  input  wire logic        bv,
  output logic             bry,
  output logic [4:0]       ara,
  output logic             arv,
  input  wire logic        arr,
  input  wire logic [31:0] rd,
  input  wire logic [1:0]  rr,
  input  wire logic        rv,
  output logic             rry,
  input  wire logic        ack_en,
  input  wire logic        oirq,
  input  wire logic        cirq,
  output logic             oack,
  output logic             cack
);
  initial begin
    awa = 5'h00;
    awv = 1'b0;
    wd  = 32'h0;
    ws  = 4'hf;
    wv  = 1'b0;
    bry = 1'b0;
    ara = 5'h00;
    arv = 1'b0;
    rry = 1'b0;
  end

  // Interrupt execution: acknowledge pulses on alternate clocks while a request is raised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oack <= 1'b0;
      cack <= 1'b0;
    end else begin
      oack <= ack_en && oirq && !oack;
      cack <= ack_en && cirq && !cack;
    end
  end

  task automatic put(input logic [4:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv);
    r = br;
    bry <= 1'b0;
  endtask

  task automatic get(input logic [4:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the eight-bit timer with compare channel
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0]  a_ctl = tc8_pkg::TC8_ADDR_CTRL;
  localparam logic [4:0]  a_cnt = tc8_pkg::TC8_ADDR_COUNT;
  localparam logic [4:0]  a_cmp = tc8_pkg::TC8_ADDR_CMP;
  localparam logic [4:0]  a_flg = tc8_pkg::TC8_ADDR_FLAG;
  localparam logic [4:0]  a_msk = tc8_pkg::TC8_ADDR_MASK;
  localparam logic [4:0]  a_sta = tc8_pkg::TC8_ADDR_STAT;
  localparam logic [31:0] all   = 32'hffffffff;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin = 1'b0;
  logic        gie = 1'b0;
  logic        ack_en = 1'b0;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic        awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
  logic        oirq, cirq, oack, cack, out;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #25 clk = ~clk;

  tc8_timer dut (
    .CLK(clk), .RESET(rst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .EXTERNAL_COUNT_PIN(pin),
    .GLOBAL_INT_EN(gie), .OVF_INT_ACK(oack), .CMP_INT_ACK(cack),
    .OVF_IRQ(oirq), .CMP_IRQ(cirq), .COMPARE_OUTPUT_STATE(out));

  tc8_host host (
    .clk(clk), .rst(rst), .awa(awa), .awv(awv), .awr(awr), .wd(wd),
    .ws(ws), .wv(wv), .wrd(wrd), .br(br), .bv(bv), .bry(bry),
    .ara(ara), .arv(arv), .arr(arr), .rd(rdat), .rr(rr), .rv(rv),
    .rry(rry), .ack_en(ack_en), .oirq(oirq), .cirq(cirq),
    .oack(oack), .cack(cack));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] cw(logic [2:0] cs, logic [1:0] wgm,
                                     logic [1:0] com, logic f);
    return {24'h0, f, com, wgm, cs};
  endfunction

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.put(a, d, r);
    chk({30'h0, r}, {30'h0, tc8_pkg::TC8_RESP_OKAY});
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.get(a, d, r);
    chk(d & m, e);
  endtask

  // Rising edges on the count pin, each held two clocks
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      pin <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) rd(5'(i * 4), all, 32'h0);
    rd(a_sta, all, 32'h1);
    chk({29'h0, oirq, cirq, out}, 32'h0);
    host.get(5'h18, d, r);
    chk({30'h0, r}, {30'h0, tc8_pkg::TC8_RESP_SLV});
    host.put(a_sta, 32'h0, r);
    chk({30'h0, r}, {30'h0, tc8_pkg::TC8_RESP_SLV});
  endtask

  task automatic t_stop();
    wr(a_cnt, 32'h1a5a);
    pulse(3);
    rd(a_cnt, all, 32'h5a);
    rd(a_flg, all, 32'h0);
    wr(a_cnt, 32'hff);
    rd(a_sta, all, 32'h2);
  endtask

  task automatic t_normal();
    wr(a_cnt, 32'hfe);
    wr(a_ctl, cw(3'h7, 2'h0, 2'h0, 1'b0));
    pulse(3);
    rd(a_cnt, all, 32'h01);
    rd(a_flg, all, 32'h3);
    wr(a_flg, 32'h3);
    rd(a_flg, all, 32'h0);
    wr(a_ctl, cw(3'h6, 2'h0, 2'h0, 1'b0));
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(a_cnt, all, 32'h01);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    rd(a_cnt, all, 32'h02);
  endtask

  task automatic t_block();
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    wr(a_cmp, 32'h10);
    wr(a_cnt, 32'h10);
    wr(a_ctl, cw(3'h7, 2'h0, 2'h0, 1'b0));
    pulse(1);
    rd(a_cnt, all, 32'h11);
    rd(a_flg, 32'h2, 32'h0);
    wr(a_cnt, 32'h0f);
    pulse(2);
    rd(a_flg, 32'h2, 32'h2);
  endtask

  task automatic t_ctc();
    wr(a_ctl, cw(3'h0, 2'h2, 2'h0, 1'b0));
    wr(a_cmp, 32'h03);
    wr(a_cnt, 32'h00);
    wr(a_flg, 32'h3);
    wr(a_ctl, cw(3'h7, 2'h2, 2'h0, 1'b0));
    pulse(5);
    rd(a_cnt, all, 32'h01);
    rd(a_flg, all, 32'h2);
    rd(a_cmp, all, 32'h03);
  endtask

  task automatic t_force();
    logic [1:0] com [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic       want [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    wr(a_cnt, 32'h40);
    wr(a_flg, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(a_ctl, cw(3'h0, 2'h0, com[i], 1'b0));
      wr(a_ctl, cw(3'h0, 2'h0, com[i], 1'b1));
      rd(a_ctl, all, cw(3'h0, 2'h0, com[i], 1'b0));
      chk({31'h0, out}, {31'h0, want[i]});
    end
    wr(a_ctl, cw(3'h0, 2'h3, 2'h0, 1'b0));
    chk({31'h0, out}, 32'h1);
    rd(a_cnt, all, 32'h40);
    rd(a_flg, all, 32'h0);
  endtask

  task automatic t_buf();
    wr(a_cmp, 32'h12);
    rd(a_cmp, all, 32'h12);
    wr(a_cnt, 32'h10);
    wr(a_ctl, cw(3'h7, 2'h3, 2'h0, 1'b0));
    pulse(3);
    rd(a_flg, 32'h2, 32'h0);
    wr(a_cnt, 32'hfe);
    pulse(2);
    rd(a_flg, all, 32'h1);
    wr(a_cnt, 32'h10);
    pulse(3);
    rd(a_flg, all, 32'h3);
  endtask

  task automatic t_irq();
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    wr(a_msk, 32'h3);
    rd(a_msk, all, 32'h3);
    chk({30'h0, oirq, cirq}, 32'h0);
    gie <= 1'b1;
    repeat (3) @(posedge clk);
    chk({30'h0, oirq, cirq}, 32'h3);
    wr(a_msk, 32'h1);
    repeat (2) @(posedge clk);
    chk({30'h0, oirq, cirq}, 32'h2);
    wr(a_msk, 32'h3);
    ack_en <= 1'b1;
    repeat (6) @(posedge clk);
    rd(a_flg, all, 32'h0);
    chk({30'h0, oirq, cirq}, 32'h0);
  endtask

  // Phase-correct turn at the top: direction flips, count steps back
  task automatic t_phase();
    wr(a_msk, 32'h0);
    wr(a_cnt, 32'hfe);
    wr(a_ctl, cw(3'h7, 2'h1, 2'h0, 1'b0));
    pulse(2);
    rd(a_cnt, all, 32'hfe);
    rd(a_sta, all, 32'h4);
  endtask

  // Undivided clock with a blocked match, then divide by eight
  task automatic t_psc();
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    wr(a_cmp, 32'h80);
    wr(a_cnt, 32'h00);
    wr(a_flg, 32'h3);
    wr(a_ctl, cw(3'h1, 2'h0, 2'h0, 1'b0));
    wr(a_cnt, 32'h80);
    rd(a_flg, 32'h2, 32'h0);
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    wr(a_cnt, 32'h00);
    wr(a_ctl, cw(3'h2, 2'h0, 2'h0, 1'b0));
    // Stop lands 20 clocks after start: ticks at clocks 8 and 16 only
    repeat (16) @(posedge clk);
    wr(a_ctl, cw(3'h0, 2'h0, 2'h0, 1'b0));
    rd(a_cnt, all, 32'h02);
  endtask

  // Reset in mid-run clears counter, compare and output state
  task automatic t_rerun();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(a_cnt, all, 32'h0);
    rd(a_cmp, all, 32'h0);
    rd(a_ctl, all, 32'h0);
    chk({31'h0, out}, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stop();
    t_normal();
    t_block();
    t_ctc();
    t_force();
    t_buf();
    t_irq();
    t_phase();
    t_psc();
    t_rerun();
    conclude();
  end
endmodule
